//--- tb/test_dual_timer_counter_with_clock_select.sv
// self-checking bench for the timer 0/1 block and clock select register
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defs.svh"
module test_dual_timer_counter_with_clock_select;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd_v, r;
  logic sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, ext_run = 1'b0, ovf, cnt_on = 1'b0;
  logic gate_input_a = 1'b0, gate_input_b = 1'b0, gate_a_polarity = 1'b1, gate_b_polarity = 1'b1;
  logic event_pin_a, event_pin_b, ext_clk_in;
  logic [1:0] ev_go = 2'h0, ack = 2'h0, irq, choice = 2'h0, ien = 2'h3;
  logic [3:0] tick;
  logic [7:0] al[8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f};
  int kk[4] = '{96, 96, 96, 128};
  int nn[4] = '{8, 24, 2, 2};
  int cnt[5];
  int bad_count = 0, n_checks = 0, cycles = 0;
  tmr_top i_tmr_top (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .event_pin_a(event_pin_a), .event_pin_b(event_pin_b), .gate_input_a(gate_input_a),
    .gate_input_b(gate_input_b), .ext_clk_in(ext_clk_in), .gate_a_polarity(gate_a_polarity),
    .gate_b_polarity(gate_b_polarity), .timer0_irq_enable(ien[0]), .timer1_irq_enable(ien[1]),
    .timer0_irq_ack(ack[0]), .timer1_irq_ack(ack[1]),
    .timer2_external_clock_choice(choice[0]), .timer3_external_clock_choice(choice[1]),
    .timer0_irq_req(irq[0]), .timer1_irq_req(irq[1]), .timer1_overflow_pulse(ovf),
    .timer2_low_tick(tick[0]), .timer2_high_tick(tick[1]), .timer3_low_tick(tick[2]),
    .timer3_high_tick(tick[3])
  );
  tmr_pin_model i_tmr_pin_model (
    .core_clk(core_clk), .ev_go(ev_go), .ext_run(ext_run),
    .event_pin_a(event_pin_a), .event_pin_b(event_pin_b), .ext_clk_in(ext_clk_in)
  );
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cnt_on) begin
      for (int i = 0; i < 4; i++) cnt[i] += tick[i];
      cnt[4] += ovf;
    end
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge core_clk);
    sfr_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge core_clk);
    sfr_rd_en <= 1'b0;
    @(negedge core_clk);
    rd_v = sfr_rdata;
  endtask
  // reference count: returns {overflow seen, high byte, low byte}
  function automatic logic [16:0] model(input logic [1:0] m, input logic [15:0] v0, input int k);
    logic [15:0] v;
    logic f;
    v = v0;
    f = 1'b0;
    for (int i = 0; i < k; i++) begin
      if (m == 2'd2) begin
        f |= (v[7:0] == 8'hff);
        v[7:0] = (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'h01;
      end else if (m == 2'd1) begin
        f |= (v == 16'hffff);
        v = v + 16'h0001;
      end else begin
        f |= ({v[15:8], v[4:0]} == 13'h1fff);
        {v[15:8], v[4:0]} = {v[15:8], v[4:0]} + 13'h0001;
      end
    end
    return {f, v};
  endfunction
  // run one timer k cycles (or n pin events), then freeze it through its gate
  task automatic trial(input int t, input logic [3:0] cfg, input logic [15:0] v0,
                       input int k, input int n, input logic [7:0] cs);
    logic [16:0] e;
    logic [7:0] rb, md, mk;
    logic [1:0] p;
    e = model(cfg[1:0], v0, n);
    rb = t ? 8'h40 : 8'h10;
    md = 8'(cfg) << (4 * t);
    mk = (cfg[1:0] == 2'd0) ? 8'h1f : 8'hff;
    p = 2'($urandom);
    // stop both timers first: a polarity flip ahead of the synced pin would open the gate
    wr(`TMR_ADDR_RUN_FLAGS, 8'h00);
    @(posedge core_clk);
    gate_a_polarity <= p[0];
    gate_input_a <= ~p[0];
    gate_b_polarity <= p[1];
    gate_input_b <= ~p[1];
    ien <= 2'($urandom);
    ext_run <= (cs == 8'h03);
    wr(`TMR_ADDR_CLK_SEL, cs);
    wr(`TMR_ADDR_MODE_CFG, md);
    wr(t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW, v0[7:0]);
    wr(t ? `TMR_ADDR_T1_HIGH : `TMR_ADDR_T0_HIGH, v0[15:8]);
    wr(`TMR_ADDR_RUN_FLAGS, rb);
    if (cfg[2]) repeat (n) begin
      ev_go[t] <= 1'b1;
      @(posedge core_clk);
      ev_go[t] <= 1'b0;
      repeat (9) @(posedge core_clk);
    end else repeat (k - 2) @(posedge core_clk);
    wr(`TMR_ADDR_MODE_CFG, md | (t ? 8'h80 : 8'h08));
    ext_run <= 1'b0;
    rd(t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW);
    chk("count low", rd_v & mk, e[7:0] & mk);
    rd(t ? `TMR_ADDR_T1_HIGH : `TMR_ADDR_T0_HIGH);
    chk("count high", rd_v, e[15:8]);
    rd(`TMR_ADDR_RUN_FLAGS);
    chk("run flags", rd_v, rb | (e[16] ? (t ? 8'h80 : 8'h20) : 8'h00));
    chk("irq request", {7'h00, irq[t]}, {7'h00, e[16] & ien[t]});
    @(posedge core_clk);
    ack[t] <= 1'b1;
    @(posedge core_clk);
    ack[t] <= 1'b0;
    rd(`TMR_ADDR_RUN_FLAGS);
    chk("flag after ack", rd_v, rb);
    chk("irq after ack", {7'h00, irq[t]}, 8'h00);
  endtask
  initial begin
    void'($urandom(32'h7a31086f));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (al[i]) begin
      rd(al[i]);
      chk("reset value", rd_v, 8'h00);
    end
    r = 8'($urandom);
    wr(`TMR_ADDR_CLK_SEL, r);
    rd(`TMR_ADDR_CLK_SEL);
    chk("clock select", rd_v, r);
    wr(`TMR_ADDR_CLK_SEL, 8'hf0);
    repeat (3) @(posedge core_clk);
    chk("fast ticks", {4'h0, tick}, 8'h0f);
    choice <= 2'b10;
    ext_run <= 1'b1;
    wr(`TMR_ADDR_CLK_SEL, 8'h00);
    repeat (20) @(posedge core_clk);
    cnt = '{default: 0};
    cnt_on <= 1'b1;
    repeat (192) @(posedge core_clk);
    cnt_on <= 1'b0;
    ext_run <= 1'b0;
    foreach (nn[i]) chk("timer 2/3 ticks", 8'(cnt[i]), (i < 2) ? 8'h10 : 8'h03);
    // split: timer 1 free-runs on its mode, no flag, then stops in mode 3
    wr(`TMR_ADDR_RUN_FLAGS, 8'h00);
    wr(`TMR_ADDR_MODE_CFG, 8'h00);
    wr(`TMR_ADDR_CLK_SEL, 8'h0c);
    wr(`TMR_ADDR_T1_LOW, 8'hfe);
    wr(`TMR_ADDR_T1_HIGH, 8'hff);
    cnt = '{default: 0};
    cnt_on <= 1'b1;
    wr(`TMR_ADDR_MODE_CFG, 8'h13);
    repeat (6) @(posedge core_clk);
    cnt_on <= 1'b0;
    chk("t1 overflow pulses", 8'(cnt[4]), 8'h01);
    rd(`TMR_ADDR_RUN_FLAGS);
    chk("no t1 flag", rd_v, 8'h00);
    wr(`TMR_ADDR_MODE_CFG, 8'h33);
    wr(`TMR_ADDR_T1_LOW, 8'h5a);
    repeat (10) @(posedge core_clk);
    rd(`TMR_ADDR_T1_LOW);
    chk("t1 held", rd_v, 8'h5a);
    wr(`TMR_ADDR_T0_LOW, 8'h55);
    wr(`TMR_ADDR_T0_HIGH, 8'hfe);
    wr(`TMR_ADDR_RUN_FLAGS, 8'h40);
    repeat (2) @(posedge core_clk);
    wr(`TMR_ADDR_MODE_CFG, 8'h30);
    rd(`TMR_ADDR_T0_HIGH);
    chk("split high", rd_v, 8'h02);
    rd(`TMR_ADDR_T0_LOW);
    chk("split low", rd_v, 8'h55);
    rd(`TMR_ADDR_RUN_FLAGS);
    chk("split flag", rd_v, 8'hc0);
    chk("split irq", {7'h00, irq[1]}, 8'h01);
    rd(`TMR_ADDR_T1_LOW);
    chk("t1 inactive", rd_v, 8'h5a);
    // corner cases, prescaler choices, pin events, then random runs
    trial(0, 4'h0, 16'hff1d, 5, 5, 8'h0c);
    for (int t = 0; t < 2; t++) trial(t, 4'h2, 16'h80fe, 5, 5, 8'h0c);
    trial(1, 4'h1, 16'h0000, 96, 24, 8'h01);
    for (int s = 0; s < 4; s++) trial(0, 4'h1, 16'h0000, kk[s], nn[s], 8'(s));
    for (int t = 0; t < 2; t++) trial(t, 4'h5, 16'h00fe, 0, 3, 8'h0c);
    for (int i = 0; i < 40; i++) begin
      r = 8'($urandom_range(40, 3));
      trial(i % 2, 4'($urandom_range(2)), 16'($urandom), r, r, 8'h0c);
    end
    finish_test();
  end
endmodule
`default_nettype wire

//--- tb/tmr_pin_model.sv
// far-side model of the event pins and the external clock pin
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
  // clock
  input wire logic core_clk,
  // requests from the bench
  input wire logic [1:0] ev_go,
  input wire logic ext_run,
  // pins
  output logic event_pin_a,
  output logic event_pin_b,
  output logic ext_clk_in
);
  logic [2:0] ph_a_r = 3'h0;
  logic [2:0] ph_b_r = 3'h0;
  logic [2:0] ph_x_r = 3'h0;
  // each level held 3 or more cycles so the sampler never misses it
  always_ff @(posedge core_clk) begin
    ph_a_r <= (ph_a_r != 3'h0) ? ph_a_r + 3'h1 : {2'h0, ev_go[0]};
    ph_b_r <= (ph_b_r != 3'h0) ? ph_b_r + 3'h1 : {2'h0, ev_go[1]};
    ph_x_r <= ext_run ? ph_x_r + 3'h1 : 3'h0;
  end
  assign event_pin_a = (ph_a_r == 3'h0) || ph_a_r[2];
  assign event_pin_b = (ph_b_r == 3'h0) || ph_b_r[2];
  // idle high between bursts; one fall every 8 cycles while running
  assign ext_clk_in = !ext_run || !ph_x_r[2];
endmodule
`default_nettype wire

//--- verilog/tmr_defs.svh
// register addresses, field positions, reset values and divider counts
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_ADDR_RUN_FLAGS 8'h88
`define TMR_ADDR_MODE_CFG 8'h89
`define TMR_ADDR_T0_LOW 8'h8a
`define TMR_ADDR_T1_LOW 8'h8b
`define TMR_ADDR_T0_HIGH 8'h8c
`define TMR_ADDR_T1_HIGH 8'h8d
`define TMR_ADDR_CLK_SEL 8'h8e
`define TMR_RST_BYTE 8'h00
`define TMR_RD_UNMAPPED 8'h00
`define TMR_BYTE_ONES 8'hff
`define TMR_BYTE_ONE 8'h01
// run/flag register
`define TMR_TF1_BIT 7
`define TMR_TR1_BIT 6
`define TMR_TF0_BIT 5
`define TMR_TR0_BIT 4
// mode register
`define TMR_TIMER1_GATE_ENABLE_BIT 7
`define TMR_CT1_BIT 6
`define TMR_T1M_LSB 4
`define TMR_TIMER0_GATE_ENABLE_BIT 3
`define TMR_CT0_BIT 2
`define TMR_T0M_LSB 0
// clock select register
`define TMR_TIMER3_HIGH_CLOCK_SEL_BIT 7
`define TMR_TIMER3_LOW_CLOCK_SEL_BIT 6
`define TMR_TIMER2_HIGH_CLOCK_SEL_BIT 5
`define TMR_TIMER2_LOW_CLOCK_SEL_BIT 4
`define TMR_T1M_BIT 3
`define TMR_T0M_BIT 2
`define TMR_SCA_LSB 0
// prescaler terminal counts (divide by 12, 4, 48, external by 8)
`define TMR_DIV12_LAST 4'hb
`define TMR_DIV4_LAST 2'h3
`define TMR_DIV48_LAST 6'h2f
`define TMR_EXT8_LAST 3'h7
// pin synchroniser lanes
`define TMR_PIN_EV_A 0
`define TMR_PIN_EV_B 1
`define TMR_PIN_GATE_A 2
`define TMR_PIN_GATE_B 3
`define TMR_PIN_EXT_CLK 4
`define TMR_PIN_COUNT 5
`endif

//--- verilog/tmr_pkg.sv
// types shared by the timer block
`default_nettype none
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_MODE13,
    TMR_MODE16,
    TMR_MODE8R,
    TMR_MODESPLIT
  } tmr_mode_type;
  typedef enum logic [1:0] {
    TMR_SCA_DIV12,
    TMR_SCA_DIV4,
    TMR_SCA_DIV48,
    TMR_SCA_EXT8
  } tmr_sca_type;
endpackage
`default_nettype wire

//--- verilog/tmr_prescale.sv
// shared timer 0/1 prescaler plus the divide-by-12 and external/8 ticks
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defs.svh"
module tmr_prescale import tmr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // controls
  input wire logic [1:0] clock_divider_select,
  input wire logic ext_edge,
  // one-cycle ticks
  output logic scaled_tick,
  output logic div12_tick,
  output logic ext8_tick
);
  logic [3:0] cnt12_r;
  logic [1:0] cnt4_r;
  logic [5:0] cnt48_r;
  logic [2:0] cnt8_r;
  logic t12_r;
  logic t4_r;
  logic t48_r;
  logic t8_r;
  logic sel_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt12_r <= '0;
      cnt4_r <= '0;
      cnt48_r <= '0;
      t12_r <= 1'b0;
      t4_r <= 1'b0;
      t48_r <= 1'b0;
    end else begin
      cnt12_r <= (cnt12_r == `TMR_DIV12_LAST) ? '0 : cnt12_r + 4'h1;
      cnt4_r <= cnt4_r + 2'h1;
      cnt48_r <= (cnt48_r == `TMR_DIV48_LAST) ? '0 : cnt48_r + 6'h01;
      t12_r <= cnt12_r == `TMR_DIV12_LAST;
      t4_r <= cnt4_r == `TMR_DIV4_LAST;
      t48_r <= cnt48_r == `TMR_DIV48_LAST;
    end
  end

  // external clock already resynchronised; one tick per eight edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt8_r <= '0;
      t8_r <= 1'b0;
    end else begin
      if (ext_edge) begin
        cnt8_r <= cnt8_r + 3'h1;
      end
      t8_r <= ext_edge & (cnt8_r == `TMR_EXT8_LAST);
    end
  end

  always_comb begin
    case (tmr_sca_type'(clock_divider_select))
      TMR_SCA_DIV12: sel_r = t12_r;
      TMR_SCA_DIV4: sel_r = t4_r;
      TMR_SCA_DIV48: sel_r = t48_r;
      TMR_SCA_EXT8: sel_r = t8_r;
      default: sel_r = 1'b0;
    endcase
  end

  assign scaled_tick = sel_r;
  assign div12_tick = t12_r;
  assign ext8_tick = t8_r;

  a_div12_spacing: assert property (@(posedge core_clk) disable iff (!arst_n)
    t12_r |=> !t12_r [*8])
    else $error("divide-by-12 tick repeats too soon");
endmodule
`default_nettype wire

//--- verilog/tmr_sync.sv
// three-stage pin synchroniser with settled level and falling-edge pulse
`timescale 1ns/1ns
`default_nettype none
module tmr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // raw pins and settled view
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] fall
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] fall_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else begin
      ff1_r <= pin_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_r <= '0;
      fall_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2_r[i] == ff3_r[i]) begin
          lvl_r[i] <= ff3_r[i];
        end
        fall_r[i] <= lvl_r[i] & (ff2_r[i] == ff3_r[i]) & ~ff3_r[i];
      end
    end
  end

  assign level = lvl_r;
  assign fall = fall_r;

  a_fall_from_high: assert property (@(posedge core_clk) disable iff (!arst_n)
    fall_r[0] |-> ($past(lvl_r[0], 2) && !lvl_r[0]))
    else $error("edge pulse without a settled high-to-low change");
endmodule
`default_nettype wire

//--- verilog/tmr_top.sv
// timer 0/1 counter pair with the shared timer clock select register
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defs.svh"
module tmr_top import tmr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // pins
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic ext_clk_in,
  // settings held elsewhere in the core
  input wire logic gate_a_polarity,
  input wire logic gate_b_polarity,
  input wire logic timer0_irq_enable,
  input wire logic timer1_irq_enable,
  input wire logic timer0_irq_ack,
  input wire logic timer1_irq_ack,
  input wire logic timer2_external_clock_choice,
  input wire logic timer3_external_clock_choice,
  // interrupt and overflow outputs
  output logic timer0_irq_req,
  output logic timer1_irq_req,
  output logic timer1_overflow_pulse,
  // timer 2/3 tick enables
  output logic timer2_low_tick,
  output logic timer2_high_tick,
  output logic timer3_low_tick,
  output logic timer3_high_tick
);
  logic [7:0] timer_clock_select_r;
  logic [7:0] timer_mode_config_r;
  logic timer0_overflow_flag_r;
  logic timer1_overflow_flag_r;
  logic timer0_run_r;
  logic timer1_run_r;
  logic [7:0] tl0_r;
  logic [7:0] th0_r;
  logic [7:0] tl1_r;
  logic [7:0] th1_r;
  logic [7:0] rdata_r;
  logic irq0_r;
  logic irq1_r;
  logic t1_ovf_r;
  logic t2l_r;
  logic t2h_r;
  logic t3l_r;
  logic t3h_r;

  logic [`TMR_PIN_COUNT-1:0] pin_raw;
  logic [`TMR_PIN_COUNT-1:0] pin_lvl;
  logic [`TMR_PIN_COUNT-1:0] pin_fall;
  logic presc_tick;
  logic div12_tick;
  logic ext8_tick;

  tmr_mode_type t0_mode;
  tmr_mode_type t1_mode;
  logic t0_split;
  logic gate_a_act;
  logic gate_b_act;
  logic t0_timer_tick;
  logic t1_timer_tick;
  logic t0_inc;
  logic t1_inc;
  logic th0_inc;
  logic [16:0] step0;
  logic [16:0] step1;
  logic ovf0;
  logic ovf1;
  logic th0_ovf;
  logic flag1_set;
  logic wr_timer_run_flags;
  logic wr_timer_mode_config;
  logic wr_timer_clock_select;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;

  // one count step: {overflow, high byte, low byte}
  function automatic logic [16:0] tmr_step(tmr_mode_type mode, logic [7:0] hi,
                                           logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [16:0] res;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      TMR_MODE13: res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      TMR_MODE16: res = s16;
      TMR_MODE8R: begin
        if (lo == `TMR_BYTE_ONES) begin
          res = {1'b1, hi, hi};
        end else begin
          res = {1'b0, hi, lo + `TMR_BYTE_ONE};
        end
      end
      default: res = {lo == `TMR_BYTE_ONES, hi, lo + `TMR_BYTE_ONE};
    endcase
    return res;
  endfunction

  assign pin_raw = {ext_clk_in, gate_input_b, gate_input_a, event_pin_b, event_pin_a};

  tmr_sync #(.W(`TMR_PIN_COUNT)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_in(pin_raw),
    .level(pin_lvl),
    .fall(pin_fall)
  );

  tmr_prescale u_presc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clock_divider_select(timer_clock_select_r[`TMR_SCA_LSB +: 2]),
    .ext_edge(pin_fall[`TMR_PIN_EXT_CLK]),
    .scaled_tick(presc_tick),
    .div12_tick(div12_tick),
    .ext8_tick(ext8_tick)
  );

  // register port decode
  always_comb begin
    wr_timer_run_flags = sfr_wr_en && sfr_addr == `TMR_ADDR_RUN_FLAGS;
    wr_timer_mode_config = sfr_wr_en && sfr_addr == `TMR_ADDR_MODE_CFG;
    wr_timer_clock_select = sfr_wr_en && sfr_addr == `TMR_ADDR_CLK_SEL;
    wr_tl0 = sfr_wr_en && sfr_addr == `TMR_ADDR_T0_LOW;
    wr_th0 = sfr_wr_en && sfr_addr == `TMR_ADDR_T0_HIGH;
    wr_tl1 = sfr_wr_en && sfr_addr == `TMR_ADDR_T1_LOW;
    wr_th1 = sfr_wr_en && sfr_addr == `TMR_ADDR_T1_HIGH;
  end

  // count enables
  always_comb begin
    t0_mode = tmr_mode_type'(timer_mode_config_r[`TMR_T0M_LSB +: 2]);
    t1_mode = tmr_mode_type'(timer_mode_config_r[`TMR_T1M_LSB +: 2]);
    t0_split = t0_mode == TMR_MODESPLIT;
    gate_a_act = pin_lvl[`TMR_PIN_GATE_A] == gate_a_polarity;
    gate_b_act = pin_lvl[`TMR_PIN_GATE_B] == gate_b_polarity;
    t0_timer_tick = timer_clock_select_r[`TMR_T0M_BIT] | presc_tick;
    t1_timer_tick = timer_clock_select_r[`TMR_T1M_BIT] | presc_tick;
    t0_inc = timer0_run_r
      & (~timer_mode_config_r[`TMR_TIMER0_GATE_ENABLE_BIT] | gate_a_act)
      & (timer_mode_config_r[`TMR_CT0_BIT] ? pin_fall[`TMR_PIN_EV_A]
                                           : t0_timer_tick);
    // split high byte: plain timer, run by timer 1's run bit, no gate
    th0_inc = t0_split & timer1_run_r & t0_timer_tick;
    if (t0_split) begin
      t1_inc = (t1_mode != TMR_MODESPLIT) & t1_timer_tick;
    end else begin
      t1_inc = timer1_run_r & (t1_mode != TMR_MODESPLIT)
        & (~timer_mode_config_r[`TMR_TIMER1_GATE_ENABLE_BIT] | gate_b_act)
        & (timer_mode_config_r[`TMR_CT1_BIT] ? pin_fall[`TMR_PIN_EV_B]
                                             : t1_timer_tick);
    end
    step0 = tmr_step(t0_mode, th0_r, tl0_r);
    step1 = tmr_step(t1_mode, th1_r, tl1_r);
    ovf0 = t0_inc & step0[16];
    ovf1 = t1_inc & step1[16];
    th0_ovf = th0_inc & (th0_r == `TMR_BYTE_ONES);
    flag1_set = t0_split ? th0_ovf : ovf1;
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_clock_select_r <= `TMR_RST_BYTE;
      timer_mode_config_r <= `TMR_RST_BYTE;
      timer0_run_r <= 1'b0;
      timer1_run_r <= 1'b0;
    end else begin
      if (wr_timer_clock_select) begin
        timer_clock_select_r <= sfr_wdata;
      end
      if (wr_timer_mode_config) begin
        timer_mode_config_r <= sfr_wdata;
      end
      if (wr_timer_run_flags) begin
        timer0_run_r <= sfr_wdata[`TMR_TR0_BIT];
        timer1_run_r <= sfr_wdata[`TMR_TR1_BIT];
      end
    end
  end

  // overflow flags: hardware set beats software or vector clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer0_overflow_flag_r <= 1'b0;
      timer1_overflow_flag_r <= 1'b0;
    end else begin
      if (ovf0) begin
        timer0_overflow_flag_r <= 1'b1;
      end else if (timer0_irq_ack) begin
        timer0_overflow_flag_r <= 1'b0;
      end else if (wr_timer_run_flags) begin
        timer0_overflow_flag_r <= sfr_wdata[`TMR_TF0_BIT];
      end
      if (flag1_set) begin
        timer1_overflow_flag_r <= 1'b1;
      end else if (timer1_irq_ack) begin
        timer1_overflow_flag_r <= 1'b0;
      end else if (wr_timer_run_flags) begin
        timer1_overflow_flag_r <= sfr_wdata[`TMR_TF1_BIT];
      end
    end
  end

  // timer 0 count bytes; a software write wins over a count step
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tl0_r <= `TMR_RST_BYTE;
      th0_r <= `TMR_RST_BYTE;
    end else begin
      if (wr_tl0) begin
        tl0_r <= sfr_wdata;
      end else if (t0_inc) begin
        tl0_r <= step0[7:0];
      end
      if (wr_th0) begin
        th0_r <= sfr_wdata;
      end else if (th0_inc) begin
        th0_r <= th0_r + `TMR_BYTE_ONE;
      end else if (t0_inc && !t0_split) begin
        th0_r <= step0[15:8];
      end
    end
  end

  // timer 1 count bytes; run bit alone never touches them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tl1_r <= `TMR_RST_BYTE;
      th1_r <= `TMR_RST_BYTE;
    end else begin
      if (wr_tl1) begin
        tl1_r <= sfr_wdata;
      end else if (t1_inc) begin
        tl1_r <= step1[7:0];
      end
      if (wr_th1) begin
        th1_r <= sfr_wdata;
      end else if (t1_inc) begin
        th1_r <= step1[15:8];
      end
    end
  end

  // read data, registered on the read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `TMR_RST_BYTE;
    end else if (sfr_rd_en) begin
      case (sfr_addr)
        `TMR_ADDR_RUN_FLAGS: begin
          rdata_r <= `TMR_RST_BYTE;
          rdata_r[`TMR_TF1_BIT] <= timer1_overflow_flag_r;
          rdata_r[`TMR_TR1_BIT] <= timer1_run_r;
          rdata_r[`TMR_TF0_BIT] <= timer0_overflow_flag_r;
          rdata_r[`TMR_TR0_BIT] <= timer0_run_r;
        end
        `TMR_ADDR_MODE_CFG: rdata_r <= timer_mode_config_r;
        `TMR_ADDR_CLK_SEL: rdata_r <= timer_clock_select_r;
        `TMR_ADDR_T0_LOW: rdata_r <= tl0_r;
        `TMR_ADDR_T0_HIGH: rdata_r <= th0_r;
        `TMR_ADDR_T1_LOW: rdata_r <= tl1_r;
        `TMR_ADDR_T1_HIGH: rdata_r <= th1_r;
        default: rdata_r <= `TMR_RD_UNMAPPED;
      endcase
    end
  end

  // interrupt requests, timer 1 overflow pulse and timer 2/3 ticks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      t1_ovf_r <= 1'b0;
      t2l_r <= 1'b0;
      t2h_r <= 1'b0;
      t3l_r <= 1'b0;
      t3h_r <= 1'b0;
    end else begin
      irq0_r <= timer0_overflow_flag_r & timer0_irq_enable;
      irq1_r <= timer1_overflow_flag_r & timer1_irq_enable;
      // consumers still see timer 1 wrap while split hands its flag to timer 0's high byte
      t1_ovf_r <= ovf1;
      t2l_r <= timer_clock_select_r[`TMR_TIMER2_LOW_CLOCK_SEL_BIT]
        | (timer2_external_clock_choice ? ext8_tick : div12_tick);
      t2h_r <= timer_clock_select_r[`TMR_TIMER2_HIGH_CLOCK_SEL_BIT]
        | (timer2_external_clock_choice ? ext8_tick : div12_tick);
      t3l_r <= timer_clock_select_r[`TMR_TIMER3_LOW_CLOCK_SEL_BIT]
        | (timer3_external_clock_choice ? ext8_tick : div12_tick);
      t3h_r <= timer_clock_select_r[`TMR_TIMER3_HIGH_CLOCK_SEL_BIT]
        | (timer3_external_clock_choice ? ext8_tick : div12_tick);
    end
  end

  assign sfr_rdata = rdata_r;
  assign timer0_irq_req = irq0_r;
  assign timer1_irq_req = irq1_r;
  assign timer1_overflow_pulse = t1_ovf_r;
  assign timer2_low_tick = t2l_r;
  assign timer2_high_tick = t2h_r;
  assign timer3_low_tick = t3l_r;
  assign timer3_high_tick = t3h_r;

  a_flag0_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    ovf0 |=> timer0_overflow_flag_r ##1 (timer0_irq_req == timer0_irq_enable))
    else $error("timer 0 wrap did not raise flag and request");
  a_count_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!timer0_run_r && !wr_tl0 && !wr_th0 && !t0_split) |=> $stable({th0_r, tl0_r}))
    else $error("timer 0 moved while stopped");
  a_reload_value: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t0_mode == TMR_MODE8R && ovf0 && !wr_tl0 && !wr_th0)
      |=> (tl0_r == $past(th0_r)) && $stable(th0_r))
    else $error("reload did not copy the high byte");
  a_split_flag1: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t0_split && !th0_ovf && !wr_timer_run_flags && !timer1_irq_ack) |=> $stable(timer1_overflow_flag_r))
    else $error("timer 1 flag moved without high byte wrap in split");
  a_t1_stopped: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t0_split && t1_mode == TMR_MODESPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1_r, tl1_r}))
    else $error("timer 1 ran in mode 3");
  a_event_only: assert property (@(posedge core_clk) disable iff (!arst_n)
    (timer_mode_config_r[`TMR_CT0_BIT] && !pin_fall[`TMR_PIN_EV_A] && !wr_tl0 && !wr_th0
      && !t0_split) |=> $stable({th0_r, tl0_r}))
    else $error("timer 0 counted without an event edge");
  a_ack_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
    (timer0_irq_ack && !ovf0) |=> !timer0_overflow_flag_r ##1 !timer0_irq_req)
    else $error("vector acknowledge did not clear timer 0 flag");
  a_t2_fast_tick: assert property (@(posedge core_clk) disable iff (!arst_n)
    (timer_clock_select_r[`TMR_TIMER2_LOW_CLOCK_SEL_BIT] && !wr_timer_clock_select) [*2] |-> timer2_low_tick)
    else $error("timer 2 low byte not on system clock");
  a_mode13_wrap: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t0_mode == TMR_MODE13 && t0_inc && !wr_tl0 && !wr_th0)
      |=> tl0_r[7:5] == $past(tl0_r[7:5]))
    else $error("13-bit count touched low byte bits 7..5");
endmodule
`default_nettype wire
